// [bench/fbcsw_master_model.sv]
// fieldbus master model: passes command bits, runs the link watchdog
`timescale 1ns/1ps
module fbcsw_master_model #(
   parameter int unsigned HALF_CYC = 8
) (
   input  wire logic        clk_in,
   input  wire logic        nrst_in,
   input  wire logic [15:0] req_in,
   output logic      [15:0] cmd_out
);
   logic [7:0] cnt_q;
   logic       wd_q;
   // watchdog square wave
   // half period shortened from half a second to keep runs short
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         cnt_q <= 8'h00;
         wd_q  <= 1'b0;
      end
      else if (cnt_q == 8'(HALF_CYC - 1))
      begin
         cnt_q <= 8'h00;
         wd_q  <= ~wd_q;
      end
      else
         cnt_q <= cnt_q + 8'h01;
   end
   assign cmd_out = {1'b0, req_in[14:12], wd_q, req_in[10:0]};
endmodule // fbcsw_master_model

// [bench/fbcsw_top_tb.sv]
// testbench for the fieldbus command/status word block
`timescale 1ns/1ps
module fbcsw_top_tb;
   import fbcsw_pkg::*;
   logic          clk = 1'b0;
   logic          nrst = 1'b0;
   logic          en = 1'b1;
   logic [15:0]   req = 16'h0000;
   logic [15:0]   cmd_w;
   fbcsw_drive_t  drv = '0;
   fbcsw_events_t evt = '0;
   logic [15:0]   vref = 16'h0000;
   logic [15:0]   vact = 16'h0000;
   logic [15:0]   vthr = 16'h0000;
   fbcsw_cmd_t    dcmd;
   logic [15:0]   st;
   logic [15:0]   fsum;
   logic [15:0]   wsum;
   logic          exp_wd = 1'b0;
   int            error_cnt = 0;
   int            n_tests = 0;

   always #2 clk = ~clk;
   always @(posedge clk) exp_wd <= cmd_w[11];

   fbcsw_master_model i_fbcsw_master_model (.clk_in(clk), .nrst_in(nrst),
      .req_in(req), .cmd_out(cmd_w));
   fbcsw_top i_fbcsw_top (.CLK_SYS_IN(clk), .NRST_IN(nrst), .CLK_EN_IN(en),
      .BUS_COMMAND_WORD_IN(cmd_w), .DRIVE_STATE_IN(drv), .EVENTS_IN(evt),
      .DC_VOLTAGE_REF_IN(vref), .DC_VOLTAGE_ACT_IN(vact),
      .DC_LEVEL_THRESHOLD_IN(vthr), .DRIVE_CMD_OUT(dcmd),
      .BUS_STATE_WORD_OUT(st), .FAULT_SUMMARY_TEN_OUT(fsum),
      .WARNING_SUMMARY_TEN_OUT(wsum));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
      input string msg);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h want %h", $time, msg, seen, exp);
      end
   endtask

   // apply a request on an edge, let n edges pass, then stop at the
   // falling edge so outputs are settled when they are looked at
   task automatic put(input logic [15:0] w, input int n);
      @(posedge clk);
      req <= w;
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   function automatic logic [15:0] cw();
      return {9'h000, dcmd};
   endfunction

   task automatic t_charge();
      put(16'h7409, 1);
      chk(cw(), 16'h0057, "charge first");
      put(16'h7409, 0);
      chk(cw(), 16'h0077, "breaker after contactor");
      put(16'h0408, 1);
      chk({15'h0, dcmd.main_breaker}, 16'h0000, "breaker open");
      chk(cw(), 16'h0010, "run alone");
      for (int i = 0; i < 3; i++)
      begin
         put(16'h0400 | (16'h1000 << i), 1);
         chk({13'h0, dcmd.virtual_inputs}, 16'(1 << i), "vin");
      end
      chk({15'h0, dcmd.front_end_run}, 16'h0000, "run stopped");
      $display("test charge done");
   endtask

   task automatic t_gate();
      put(16'h7889, 2);
      chk(cw(), 16'h0000, "gated cmd");
      chk({15'h0, st[ST_BUS_CTRL]}, 16'h0000, "bus ctrl");
      put(16'h0000, 1);
      // enable changes on a rising edge, like every other input
      @(posedge clk);
      en <= 1'b0;
      put(16'h0401, 3);
      chk(cw(), 16'h0000, "frozen");
      chk({15'h0, st[ST_BUS_CTRL]}, 16'h0000, "frozen status");
      @(posedge clk);
      en <= 1'b1;
      put(16'h0000, 2);
      $display("test gate done");
   endtask

   task automatic t_reset();
      put(16'h0400, 1);
      put(16'h0480, 1);
      chk({15'h0, dcmd.fault_reset}, 16'h0001, "reset pulse");
      for (int i = 0; i < 5; i++)
      begin
         put(16'h0480, 0);
         chk({15'h0, dcmd.fault_reset}, 16'h0000, "no repeat");
      end
      $display("test reset done");
   endtask

   task automatic t_status();
      @(posedge clk);
      drv <= 9'b111100111;
      evt <= 5'b11111;
      vref <= 16'h0100;
      vact <= 16'h0100;
      vthr <= 16'h00ff;
      put(16'h0400, 1);
      chk(st, {exp_wd, 15'h47ff}, "status all on");
      chk(fsum, 16'h0014, "fault sum");
      chk(wsum, 16'h0016, "warn sum");
      @(posedge clk);
      drv <= 9'b100011000;
      evt <= 5'b01101;
      vref <= 16'h0080;
      vthr <= 16'h0101;
      put(16'h0000, 1);
      chk(st, {exp_wd, 15'h0001}, "status mostly off");
      chk(fsum, 16'h0010, "fault temp");
      chk(wsum, 16'h0012, "warn earth temp");
      for (int i = 0; i < 20; i++)
      begin
         put(16'h0000, 0);
         chk({15'h0, st[ST_WATCHDOG]}, {15'h0, exp_wd}, "echo");
      end
      $display("test status done");
   endtask

   task automatic print_verdict();
      $display("tests %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      repeat (15) @(posedge clk);
      chk(st, 16'h0020, "reset state");
      chk(fsum | wsum | cw(), 16'h0000, "reset outputs");
      @(posedge clk);
      nrst <= 1'b1;
      t_charge();
      t_gate();
      t_reset();
      t_status();
      print_verdict();
   end

   initial
   begin
      #20000;
      error_cnt++;
      print_verdict();
   end
endmodule // fbcsw_top_tb

// [verilog/fbcsw_pkg.sv]
// package: constants and carriers for the fieldbus command/status word block
package fbcsw_pkg;
   localparam int unsigned WORD_W = 16;
   // command word bit positions
   localparam int unsigned CMD_DC_CHARGE  = 0;
   localparam int unsigned CMD_RUN        = 3;
   localparam int unsigned CMD_RESET      = 7;
   localparam int unsigned CMD_BUS_CTRL   = 10;
   localparam int unsigned CMD_WATCHDOG   = 11;
   localparam int unsigned CMD_VIN_TWO    = 12;
   localparam int unsigned CMD_VIN_FOUR   = 14;
   // status word bit positions
   localparam int unsigned ST_READY_ON    = 0;
   localparam int unsigned ST_READY_RUN   = 1;
   localparam int unsigned ST_RUNNING     = 2;
   localparam int unsigned ST_FAULT       = 3;
   localparam int unsigned ST_RUN_ENABLE  = 4;
   localparam int unsigned ST_NO_QSTOP    = 5;
   localparam int unsigned ST_BRK_OK      = 6;
   localparam int unsigned ST_WARNING     = 7;
   localparam int unsigned ST_AT_REF      = 8;
   localparam int unsigned ST_BUS_CTRL    = 9;
   localparam int unsigned ST_ABOVE_LIM   = 10;
   localparam int unsigned ST_CHARGING    = 14;
   localparam int unsigned ST_WATCHDOG    = 15;
   // summary word bit positions
   localparam int unsigned FLT_OVERLOAD   = 2;
   localparam int unsigned FLT_TEMP       = 4;
   localparam int unsigned WRN_EARTH      = 1;
   localparam int unsigned WRN_OVERLOAD   = 2;
   localparam int unsigned WRN_TEMP       = 4;
   // reset values
   localparam logic [15:0] STATUS_RST     = 16'h0020;
   localparam logic [15:0] SUMMARY_RST    = 16'h0000;

   // drive state reported by the converter control
   typedef struct packed {
      logic ready;
      logic breaker_closed;
      logic modulating;
      logic start_possible;
      logic quick_stop;
      logic breaker_fb;
      logic fault_any;
      logic warning_any;
      logic charging;
   } fbcsw_drive_t;

   // fault and warning event sources
   typedef struct packed {
      logic overload_fault;
      logic temp_fault;
      logic earth_warning;
      logic overload_warning;
      logic temp_warning;
   } fbcsw_events_t;

   // commands issued to the converter control
   typedef struct packed {
      logic       charge_contactor;
      logic       main_breaker;
      logic       front_end_run;
      logic       fault_reset;
      logic [2:0] virtual_inputs;
   } fbcsw_cmd_t;
endpackage

// [verilog/fbcsw_top.sv]
// fieldbus command word interpreter and status word builder
`timescale 1ns/1ps

// Summary of operation
// - bit0 closes charging then breaker; clear opens
// - bit3 starts or stops front-end converter
// - commands accepted only while bit10 set
// - bit11 echoed into status bit15
// - bits12-14 are virtual digital inputs
// - status bit0 ready to start charging
// - status bit1 ready and breaker closed
// - status bit2 running and modulating
// - status bit4 run enabled, start possible
// - status bit5 low while quick stop
// - status bit6 breaker feedback matches command
// - status bit8 DC reference equals actual
// - status bit9 fieldbus control in effect
// - status bit10 DC above threshold
// - status bit14 DC charging active
// - reserved status bits 11-13 zero; reserved command bits ignored
// - fault summary bits 2 and 4
// - warning summary bits 1, 2, 4
module fbcsw_top #(
   parameter int unsigned DC_W = 16
) (
   input  wire logic                 CLK_SYS_IN,
   input  wire logic                 NRST_IN,
   input  wire logic                 CLK_EN_IN,
   input  wire logic [15:0]          BUS_COMMAND_WORD_IN,
   input  wire fbcsw_pkg::fbcsw_drive_t  DRIVE_STATE_IN,
   input  wire fbcsw_pkg::fbcsw_events_t EVENTS_IN,
   input  wire logic [DC_W-1:0]      DC_VOLTAGE_REF_IN,
   input  wire logic [DC_W-1:0]      DC_VOLTAGE_ACT_IN,
   input  wire logic [DC_W-1:0]      DC_LEVEL_THRESHOLD_IN,
   output fbcsw_pkg::fbcsw_cmd_t     DRIVE_CMD_OUT,
   output logic [15:0]               BUS_STATE_WORD_OUT,
   output logic [15:0]               FAULT_SUMMARY_TEN_OUT,
   output logic [15:0]               WARNING_SUMMARY_TEN_OUT
);
   import fbcsw_pkg::*;

   logic        reset_prev_q;
   logic        bus_ctrl;
   logic        charge_req;
   logic [15:0] state_d;
   logic [15:0] fault_d;
   logic [15:0] warn_d;

   // a command bit only counts while the bus holds control
   function automatic logic gated_cmd(input logic [15:0] word,
                                      input int unsigned pos);
      return word[CMD_BUS_CTRL] && word[pos];
   endfunction

   assign bus_ctrl   = BUS_COMMAND_WORD_IN[CMD_BUS_CTRL];
   assign charge_req = gated_cmd(BUS_COMMAND_WORD_IN, CMD_DC_CHARGE);

   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
         reset_prev_q <= 1'b0;
      else if (CLK_EN_IN)
         reset_prev_q <= BUS_COMMAND_WORD_IN[CMD_RESET];
   end

   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         DRIVE_CMD_OUT <= '0;
      end
      else if (CLK_EN_IN)
      begin
         DRIVE_CMD_OUT.charge_contactor <= charge_req;
         // breaker follows one cycle behind the contactor
         DRIVE_CMD_OUT.main_breaker <=
            charge_req && DRIVE_CMD_OUT.charge_contactor;
         DRIVE_CMD_OUT.front_end_run <=
            gated_cmd(BUS_COMMAND_WORD_IN, CMD_RUN);
         // one-cycle reset on rising edge only
         DRIVE_CMD_OUT.fault_reset <=
            gated_cmd(BUS_COMMAND_WORD_IN, CMD_RESET) && !reset_prev_q;
         DRIVE_CMD_OUT.virtual_inputs <= bus_ctrl ?
            BUS_COMMAND_WORD_IN[CMD_VIN_FOUR:CMD_VIN_TWO] : 3'h0;
      end
   end

   always_comb
   begin
      state_d = 16'h0000;
      state_d[ST_READY_ON]  = DRIVE_STATE_IN.ready;
      state_d[ST_READY_RUN] = DRIVE_STATE_IN.ready &&
                              DRIVE_STATE_IN.breaker_closed;
      state_d[ST_RUNNING]   = DRIVE_STATE_IN.modulating;
      state_d[ST_FAULT]     = DRIVE_STATE_IN.fault_any;
      state_d[ST_WARNING]   = DRIVE_STATE_IN.warning_any;
      state_d[ST_RUN_ENABLE] = DRIVE_STATE_IN.start_possible;
      state_d[ST_NO_QSTOP]  = !DRIVE_STATE_IN.quick_stop;
      state_d[ST_BRK_OK]    = DRIVE_STATE_IN.breaker_fb ==
                              DRIVE_CMD_OUT.main_breaker;
      state_d[ST_AT_REF]    = DC_VOLTAGE_REF_IN == DC_VOLTAGE_ACT_IN;
      state_d[ST_BUS_CTRL]  = bus_ctrl;
      // above the threshold; equal counts as below
      state_d[ST_ABOVE_LIM] = DC_VOLTAGE_ACT_IN > DC_LEVEL_THRESHOLD_IN;
      state_d[ST_CHARGING]  = DRIVE_STATE_IN.charging;
      // watchdog echo, ungated so the loop works without control
      state_d[ST_WATCHDOG]  = BUS_COMMAND_WORD_IN[CMD_WATCHDOG];
      // bits 11..13 stay at zero from the default above
   end

   always_comb
   begin
      fault_d = 16'h0000;
      warn_d  = 16'h0000;
      fault_d[FLT_OVERLOAD] = EVENTS_IN.overload_fault;
      fault_d[FLT_TEMP]     = EVENTS_IN.temp_fault;
      warn_d[WRN_EARTH]     = EVENTS_IN.earth_warning;
      warn_d[WRN_OVERLOAD]  = EVENTS_IN.overload_warning;
      warn_d[WRN_TEMP]      = EVENTS_IN.temp_warning;
   end

   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         BUS_STATE_WORD_OUT      <= STATUS_RST;
         FAULT_SUMMARY_TEN_OUT   <= SUMMARY_RST;
         WARNING_SUMMARY_TEN_OUT <= SUMMARY_RST;
      end
      else if (CLK_EN_IN)
      begin
         BUS_STATE_WORD_OUT      <= state_d;
         FAULT_SUMMARY_TEN_OUT   <= fault_d;
         WARNING_SUMMARY_TEN_OUT <= warn_d;
      end
   end

   default clocking dcb @(posedge CLK_SYS_IN); endclocking
   default disable iff (!NRST_IN);

   a_breaker_after_charge: assert property (
      CLK_EN_IN && $rose(DRIVE_CMD_OUT.main_breaker)
      |-> $past(DRIVE_CMD_OUT.charge_contactor))
      else $error("breaker closed before contactor");
   a_breaker_open: assert property (
      CLK_EN_IN && !BUS_COMMAND_WORD_IN[CMD_DC_CHARGE]
      |=> !DRIVE_CMD_OUT.main_breaker)
      else $error("breaker not opened");
   a_run_follows: assert property (
      CLK_EN_IN |=> DRIVE_CMD_OUT.front_end_run ==
      $past(bus_ctrl && BUS_COMMAND_WORD_IN[CMD_RUN]))
      else $error("run command mismatch");
   a_reset_single: assert property (
      DRIVE_CMD_OUT.fault_reset |-> !$past(DRIVE_CMD_OUT.fault_reset)
      || !$past(CLK_EN_IN))
      else $error("fault reset repeated");
   a_no_ctrl_cmds: assert property (
      CLK_EN_IN && !bus_ctrl |=> !DRIVE_CMD_OUT.front_end_run
      && !DRIVE_CMD_OUT.charge_contactor && !DRIVE_CMD_OUT.fault_reset)
      else $error("command taken without control");
   a_wd_echo: assert property (
      CLK_EN_IN |=> BUS_STATE_WORD_OUT[ST_WATCHDOG] ==
      $past(BUS_COMMAND_WORD_IN[CMD_WATCHDOG]))
      else $error("watchdog not echoed");
   a_reserved_zero: assert property (
      BUS_STATE_WORD_OUT[13:11] == 3'h0)
      else $error("reserved status bits set");
   a_qstop_inv: assert property (
      CLK_EN_IN |=> BUS_STATE_WORD_OUT[ST_NO_QSTOP] ==
      !$past(DRIVE_STATE_IN.quick_stop))
      else $error("quick stop sense wrong");
   a_fault_mask: assert property (
      (FAULT_SUMMARY_TEN_OUT & 16'hffeb) == 16'h0000)
      else $error("fault summary stray bit");
   a_warn_mask: assert property (
      (WARNING_SUMMARY_TEN_OUT & 16'hffe9) == 16'h0000)
      else $error("warning summary stray bit");

   // command side, one enabled edge behind the command word
   a_contactor_cmd: assert property (
      NRST_IN && CLK_EN_IN |=> DRIVE_CMD_OUT.charge_contactor ==
      $past(charge_req))
      else $error("contactor command mismatch");

   a_reset_on_rise: assert property (
      NRST_IN && CLK_EN_IN && $past(NRST_IN) && $past(CLK_EN_IN)
      && bus_ctrl && $rose(BUS_COMMAND_WORD_IN[CMD_RESET])
      |=> DRIVE_CMD_OUT.fault_reset)
      else $error("fault reset missed on rise");

   a_vin_follow: assert property (
      NRST_IN && CLK_EN_IN && bus_ctrl |=> DRIVE_CMD_OUT.virtual_inputs ==
      $past(BUS_COMMAND_WORD_IN[CMD_VIN_FOUR:CMD_VIN_TWO]))
      else $error("virtual inputs mismatch");

   a_no_ctrl_vin: assert property (
      NRST_IN && CLK_EN_IN && !bus_ctrl |=> !DRIVE_CMD_OUT.main_breaker
      && DRIVE_CMD_OUT.virtual_inputs == 3'h0)
      else $error("breaker or inputs without control");

   // status word, one enabled edge behind its sources
   a_ready_on: assert property (
      NRST_IN && CLK_EN_IN |=> BUS_STATE_WORD_OUT[ST_READY_ON] ==
      $past(DRIVE_STATE_IN.ready))
      else $error("ready on bit wrong");

   a_ready_run: assert property (
      NRST_IN && CLK_EN_IN |=> BUS_STATE_WORD_OUT[ST_READY_RUN] ==
      $past(DRIVE_STATE_IN.ready && DRIVE_STATE_IN.breaker_closed))
      else $error("ready run bit wrong");

   a_running_bit: assert property (
      NRST_IN && CLK_EN_IN |=> BUS_STATE_WORD_OUT[ST_RUNNING] ==
      $past(DRIVE_STATE_IN.modulating))
      else $error("running bit wrong");

   a_run_enable: assert property (
      NRST_IN && CLK_EN_IN |=> BUS_STATE_WORD_OUT[ST_RUN_ENABLE] ==
      $past(DRIVE_STATE_IN.start_possible))
      else $error("run enable bit wrong");

   a_brk_ok: assert property (
      NRST_IN && CLK_EN_IN |=> BUS_STATE_WORD_OUT[ST_BRK_OK] ==
      ($past(DRIVE_STATE_IN.breaker_fb) ==
       $past(DRIVE_CMD_OUT.main_breaker)))
      else $error("breaker ok bit wrong");

   a_at_ref: assert property (
      NRST_IN && CLK_EN_IN |=> BUS_STATE_WORD_OUT[ST_AT_REF] ==
      ($past(DC_VOLTAGE_REF_IN) == $past(DC_VOLTAGE_ACT_IN)))
      else $error("at reference bit wrong");

   a_bus_ctrl_bit: assert property (
      NRST_IN && CLK_EN_IN |=> BUS_STATE_WORD_OUT[ST_BUS_CTRL] ==
      $past(BUS_COMMAND_WORD_IN[CMD_BUS_CTRL]))
      else $error("bus control bit wrong");

   a_above_lim: assert property (
      NRST_IN && CLK_EN_IN |=> BUS_STATE_WORD_OUT[ST_ABOVE_LIM] ==
      ($past(DC_VOLTAGE_ACT_IN) > $past(DC_LEVEL_THRESHOLD_IN)))
      else $error("above limit bit wrong");

   a_charging_bit: assert property (
      NRST_IN && CLK_EN_IN |=> BUS_STATE_WORD_OUT[ST_CHARGING] ==
      $past(DRIVE_STATE_IN.charging))
      else $error("charging bit wrong");

   a_fault_bit: assert property (
      NRST_IN && CLK_EN_IN |=> BUS_STATE_WORD_OUT[ST_FAULT] ==
      $past(DRIVE_STATE_IN.fault_any))
      else $error("fault bit wrong");

   a_warning_bit: assert property (
      NRST_IN && CLK_EN_IN |=> BUS_STATE_WORD_OUT[ST_WARNING] ==
      $past(DRIVE_STATE_IN.warning_any))
      else $error("warning bit wrong");

   // summary words follow their event sources
   a_flt_overload: assert property (
      NRST_IN && CLK_EN_IN |=> FAULT_SUMMARY_TEN_OUT[FLT_OVERLOAD] ==
      $past(EVENTS_IN.overload_fault))
      else $error("overload fault bit wrong");

   a_flt_temp: assert property (
      NRST_IN && CLK_EN_IN |=> FAULT_SUMMARY_TEN_OUT[FLT_TEMP] ==
      $past(EVENTS_IN.temp_fault))
      else $error("temperature fault bit wrong");

   a_wrn_earth: assert property (
      NRST_IN && CLK_EN_IN |=> WARNING_SUMMARY_TEN_OUT[WRN_EARTH] ==
      $past(EVENTS_IN.earth_warning))
      else $error("earth warning bit wrong");

   a_wrn_overload: assert property (
      NRST_IN && CLK_EN_IN |=> WARNING_SUMMARY_TEN_OUT[WRN_OVERLOAD] ==
      $past(EVENTS_IN.overload_warning))
      else $error("overload warning bit wrong");

   a_wrn_temp: assert property (
      NRST_IN && CLK_EN_IN |=> WARNING_SUMMARY_TEN_OUT[WRN_TEMP] ==
      $past(EVENTS_IN.temp_warning))
      else $error("temperature warning bit wrong");

   c_breaker_close: cover property (DRIVE_CMD_OUT.main_breaker);
   c_fault_reset: cover property (DRIVE_CMD_OUT.fault_reset);
   c_wd_toggle: cover property ($rose(BUS_STATE_WORD_OUT[ST_WATCHDOG]));
   c_run_start: cover property ($rose(DRIVE_CMD_OUT.front_end_run));
   c_at_ref: cover property (BUS_STATE_WORD_OUT[ST_AT_REF]);
endmodule // fbcsw_top
